/* File: cache_pkg.sv */
// Package: constants for the write-through cache and memory error capture
package cache_pkg;

    // ============================================================
    // Geometry
    // ============================================================
    localparam int DATA_W = 16;
    localparam int PAGE_W = 15;
    localparam int DISP_W = 10;
    localparam int ENTRIES = 1024;
    localparam int UPPER_W = 8;
    localparam int CODE_W = 5;

    // ============================================================
    // Internal register selectors (read and write ops)
    // ============================================================
    localparam logic [2:0] SEL_ERROR_ADDRESS_LOW = 3'h0;
    localparam logic [2:0] SEL_ERROR_STATUS_WORD = 3'h1;
    localparam logic [2:0] SEL_CACHE_STATUS_WORD = 3'h2;
    localparam logic [2:0] SEL_INVALIDATE_ALL = 3'h3;
    localparam logic [2:0] SEL_INHIBIT_LOWER = 3'h4;
    localparam logic [2:0] SEL_INHIBIT_UPPER = 3'h5;

    // ============================================================
    // Field positions
    // ============================================================
    localparam int STAT_NEXT_FILLS_BIT = 0;
    localparam int STAT_PRESENT_BIT = 1;
    localparam int STAT_SWITCH_BIT = 2;
    localparam int ERR_CODE_LSB = 8;
    localparam int ERR_FATAL_BIT = 13;
    localparam int ERR_DMA_BIT = 14;
    localparam int ERR_FETCH_BIT = 15;

    // ============================================================
    // Reset values: whole range inhibited after master clear
    // ============================================================
    localparam logic [PAGE_W-1:0] LOWER_RESET = 15'h0000;
    localparam logic [PAGE_W-1:0] UPPER_RESET = 15'h7fff;

    // ============================================================
    // Timing
    // ============================================================
    localparam int CLOCK_MHZ = 100;
    localparam int PRESENT_HOLD_US = 60;
    localparam int PRESENT_HOLD_CYCLES = PRESENT_HOLD_US * CLOCK_MHZ;

endpackage : cache_pkg

/* File: write_through_cache.sv */
// Module: direct-mapped write-through cache with memory error capture
`timescale 1ns/1ps
// =====================================================================
// =====================================================================
module write_through_cache #(
    parameter int PRESENT_HOLD = cache_pkg::PRESENT_HOLD_CYCLES,
    parameter bit OPTION_PRESENT = 1'b1
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic enable_i,
    // CPU side
    input wire logic cpu_req_i,
    input wire logic cpu_write_i,
    input wire logic cpu_fetch_i,
    input wire logic [cache_pkg::PAGE_W-1:0] physical_page_number_i,
    input wire logic [cache_pkg::DISP_W-1:0] cpu_disp_i,
    input wire logic [cache_pkg::DATA_W-1:0] cpu_wdata_i,
    output logic cpu_ack_o,
    output logic [cache_pkg::DATA_W-1:0] cpu_rdata_o,
    output logic cpu_hit_o,
    // Internal register ops
    input wire logic internal_register_read_op_i,
    input wire logic internal_register_write_op_i,
    input wire logic [2:0] reg_sel_i,
    input wire logic [cache_pkg::DATA_W-1:0] internal_cpu_data_bus_i,
    output logic [cache_pkg::DATA_W-1:0] internal_cpu_data_bus_o,
    output logic reg_valid_o,
    // Manual disable switch pin
    input wire logic switch_disable_i,
    // Main memory side
    output logic mem_req_o,
    output logic mem_write_o,
    output logic [cache_pkg::PAGE_W+cache_pkg::DISP_W-1:0] mem_addr_o,
    output logic [cache_pkg::DATA_W-1:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [cache_pkg::DATA_W-1:0] mem_rdata_i,
    // Memory error report
    input wire logic mem_error_i,
    input wire logic mem_fatal_i,
    input wire logic [cache_pkg::CODE_W-1:0] mem_code_i,
    input wire logic [23:0] mem_err_addr_i,
    input wire logic mem_err_dma_i,
    input wire logic mem_err_fetch_i
);
    import cache_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MEM = 3'b010,
        ST_DONE = 3'b100
    } state_e;

    localparam int HOLD_W = $clog2(PRESENT_HOLD + 1);

    // ================================================================
    // Storage and state
    // ================================================================
    logic [PAGE_W-1:0] tag_reg [ENTRIES];
    logic [DATA_W-1:0] data_reg [ENTRIES];
    logic [ENTRIES-1:0] valid_reg;
    logic [PAGE_W-1:0] lower_reg;
    logic [PAGE_W-1:0] upper_reg;
    logic [HOLD_W-1:0] hold_reg;
    logic [15:0] err_addr_reg;
    logic [15:0] err_stat_reg;
    logic err_lock_reg;
    logic sw_meta_reg;
    logic sw_reg;
    state_e state_reg;
    logic write_reg;
    logic fill_reg;
    logic [PAGE_W-1:0] page_reg;
    logic [DISP_W-1:0] disp_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic last_fill_reg;

    // Inclusive page-range check
    function automatic logic in_range(input logic [PAGE_W-1:0] page,
                                      input logic [PAGE_W-1:0] lo,
                                      input logic [PAGE_W-1:0] hi);
        in_range = (page >= lo) && (page <= hi);
    endfunction : in_range

    // ================================================================
    // Lookup
    // ================================================================
    logic inhibited;
    logic cache_usable;
    logic hit;
    logic reg_wr;
    logic clear_cmd;

    // Inhibit window and disable decide whether the cache takes part
    assign inhibited = in_range(physical_page_number_i, lower_reg, upper_reg);
    assign cache_usable = OPTION_PRESENT && !sw_reg && !inhibited;
    // Hit needs valid entry with matching page tag
    assign hit = cache_usable && valid_reg[cpu_disp_i]
        && (tag_reg[cpu_disp_i] == physical_page_number_i);
    assign reg_wr = internal_register_write_op_i && OPTION_PRESENT;
    assign clear_cmd = reg_wr && (reg_sel_i == SEL_INVALIDATE_ALL);

    // ================================================================
    // Switch synchroniser
    // ================================================================
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            sw_meta_reg <= 1'b0;
            sw_reg <= 1'b0;
        end
        else if (enable_i)
        begin
            sw_meta_reg <= switch_disable_i;
            sw_reg <= sw_meta_reg;
        end
    end

    // ================================================================
    // Access sequencer (DMA never reaches this port)
    // ================================================================
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_reg <= ST_IDLE;
            write_reg <= 1'b0;
            fill_reg <= 1'b0;
            page_reg <= '0;
            disp_reg <= '0;
            wdata_reg <= '0;
            cpu_ack_o <= 1'b0;
            cpu_hit_o <= 1'b0;
            cpu_rdata_o <= '0;
            mem_req_o <= 1'b0;
            mem_write_o <= 1'b0;
            mem_addr_o <= '0;
            mem_wdata_o <= '0;
        end
        else if (enable_i)
        begin
            cpu_ack_o <= 1'b0;
            cpu_hit_o <= 1'b0;
            unique case (state_reg)
                ST_IDLE:
                begin
                    if (cpu_req_i)
                    begin
                        page_reg <= physical_page_number_i;
                        disp_reg <= cpu_disp_i;
                        wdata_reg <= cpu_wdata_i;
                        write_reg <= cpu_write_i;
                        fill_reg <= cache_usable;
                        if (!cpu_write_i && hit)
                        begin
                            cpu_rdata_o <= data_reg[cpu_disp_i];
                            cpu_ack_o <= 1'b1;
                            cpu_hit_o <= 1'b1;
                        end
                        else
                        begin
                            mem_req_o <= 1'b1;
                            mem_write_o <= cpu_write_i;
                            mem_addr_o <= {physical_page_number_i, cpu_disp_i};
                            mem_wdata_o <= cpu_wdata_i;
                            state_reg <= ST_MEM;
                        end
                    end
                end
                ST_MEM:
                begin
                    if (mem_ack_i)
                    begin
                        mem_req_o <= 1'b0;
                        mem_write_o <= 1'b0;
                        cpu_rdata_o <= write_reg ? '0 : mem_rdata_i;
                        cpu_ack_o <= 1'b1;
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ================================================================
    // Entry update: write-through and miss fill
    // ================================================================
    logic do_fill;
    logic [DATA_W-1:0] fill_data;
    assign do_fill = (state_reg == ST_MEM) && mem_ack_i && fill_reg;
    assign fill_data = write_reg ? wdata_reg : mem_rdata_i;

    always_ff @(posedge clock_i)
    begin
        if (enable_i && do_fill)
        begin
            tag_reg[disp_reg] <= page_reg;
            data_reg[disp_reg] <= fill_data;
        end
    end

    // Valid flags: clear wins since it invalidates the whole table
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            valid_reg <= '0;
        end
        else if (enable_i)
        begin
            if (clear_cmd)
            begin
                valid_reg <= '0;
            end
            else if (do_fill)
            begin
                valid_reg[disp_reg] <= 1'b1;
            end
        end
    end

    // ================================================================
    // Inhibit limits, reset to whole range
    // ================================================================
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            lower_reg <= LOWER_RESET;
            upper_reg <= UPPER_RESET;
        end
        else if (enable_i && reg_wr)
        begin
            // Entries are kept when the window grows
            if (reg_sel_i == SEL_INHIBIT_LOWER)
            begin
                lower_reg <= internal_cpu_data_bus_i[PAGE_W-1:0];
            end
            if (reg_sel_i == SEL_INHIBIT_UPPER)
            begin
                upper_reg <= internal_cpu_data_bus_i[PAGE_W-1:0];
            end
        end
    end

    // ================================================================
    // Present hold-off after clear or reset
    // ================================================================
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            hold_reg <= HOLD_W'(PRESENT_HOLD);
        end
        else if (enable_i)
        begin
            if (clear_cmd)
            begin
                hold_reg <= HOLD_W'(PRESENT_HOLD);
            end
            else if (hold_reg != '0)
            begin
                hold_reg <= hold_reg - HOLD_W'(1);
            end
        end
    end

    // Remember whether the last CPU request will fill a cache entry
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            last_fill_reg <= 1'b0;
        end
        else if (enable_i && cpu_req_i && state_reg == ST_IDLE)
        begin
            last_fill_reg <= cache_usable && (cpu_write_i || !hit);
        end
    end

    // ================================================================
    // Error capture, frozen until the address word is read
    // ================================================================
    logic err_release;
    assign err_release = internal_register_read_op_i
        && (reg_sel_i == SEL_ERROR_ADDRESS_LOW);

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            err_addr_reg <= '0;
            err_stat_reg <= '0;
            err_lock_reg <= 1'b0;
        end
        else if (enable_i)
        begin
            if (!err_lock_reg || err_release)
            begin
                // Track the last reference; a new error locks (set wins)
                if (cpu_req_i || mem_error_i)
                begin
                    err_addr_reg <= mem_err_addr_i[15:0];
                    err_stat_reg <= {mem_err_fetch_i, mem_err_dma_i, mem_fatal_i,
                                     mem_error_i ? mem_code_i : 5'h00,
                                     mem_err_addr_i[23:16]};
                end
                err_lock_reg <= mem_error_i;
            end
        end
    end

    // ================================================================
    // Register read port
    // ================================================================
    logic [DATA_W-1:0] status_word;
    always_comb
    begin
        status_word = '0;
        if (OPTION_PRESENT)
        begin
            status_word[STAT_NEXT_FILLS_BIT] = last_fill_reg;
            status_word[STAT_PRESENT_BIT] = (hold_reg == '0) && !sw_reg;
            status_word[STAT_SWITCH_BIT] = sw_reg;
        end
        else
        begin
            status_word[STAT_SWITCH_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            internal_cpu_data_bus_o <= '0;
            reg_valid_o <= 1'b0;
        end
        else if (enable_i)
        begin
            reg_valid_o <= internal_register_read_op_i;
            if (internal_register_read_op_i)
            begin
                unique case (reg_sel_i)
                    SEL_ERROR_ADDRESS_LOW: internal_cpu_data_bus_o <= err_addr_reg;
                    SEL_ERROR_STATUS_WORD: internal_cpu_data_bus_o <= err_stat_reg;
                    SEL_CACHE_STATUS_WORD: internal_cpu_data_bus_o <= status_word;
                    default: internal_cpu_data_bus_o <= '0;
                endcase
            end
        end
    end

endmodule : write_through_cache

/* File: write_through_cache_monitor.sv */
// Checker of the cache port timing and answers
`timescale 1ns/1ps
module write_through_cache_monitor
import cache_pkg::*;
#(
    parameter int PRESENT_HOLD = 20,
    parameter bit OPTION_PRESENT = 1'b1
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire logic cpu_write_i,
    input wire logic [PAGE_W-1:0] physical_page_number_i,
    input wire logic [DISP_W-1:0] cpu_disp_i,
    input wire logic [DATA_W-1:0] cpu_wdata_i,
    input wire logic cpu_ack_o,
    input wire logic [DATA_W-1:0] cpu_rdata_o,
    input wire logic cpu_hit_o,
    input wire logic internal_register_read_op_i,
    input wire logic internal_register_write_op_i,
    input wire logic [2:0] reg_sel_i,
    input wire logic [DATA_W-1:0] internal_cpu_data_bus_o,
    input wire logic reg_valid_o,
    input wire logic mem_req_o,
    input wire logic mem_write_o,
    input wire logic [PAGE_W+DISP_W-1:0] mem_addr_o,
    input wire logic [DATA_W-1:0] mem_wdata_o,
    input wire logic mem_ack_i,
    input wire logic [DATA_W-1:0] mem_rdata_i
);
    // ====================
    // Sequences and properties
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    sequence s_mem_done; mem_req_o && mem_ack_i; endsequence
    sequence s_inval; internal_register_write_op_i && enable_i && reg_sel_i == 3'h3; endsequence
    sequence s_stat; internal_register_read_op_i && enable_i && reg_sel_i == 3'h2; endsequence
    property p_ack_pulse; cpu_ack_o |=> !cpu_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_hit_no_mem; cpu_hit_o |-> cpu_ack_o && !mem_req_o && !$past(mem_req_o); endproperty
    a_hit_no_mem: assert property (p_hit_no_mem) else $error("hit used memory");
    property p_issue;
        $rose(mem_req_o) |-> mem_addr_o == {physical_page_number_i, cpu_disp_i}
            && mem_write_o == cpu_write_i;
    endproperty
    a_issue: assert property (p_issue) else $error("bad memory address");
    property p_wdata; $rose(mem_req_o) && mem_write_o |-> mem_wdata_o == cpu_wdata_i; endproperty
    a_wdata: assert property (p_wdata) else $error("bad write data");
    property p_hold; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o); endproperty
    a_hold: assert property (p_hold) else $error("memory request dropped");
    property p_ack_after; s_mem_done |=> cpu_ack_o && !mem_req_o; endproperty
    a_ack_after: assert property (p_ack_after) else $error("no ack after memory");
    property p_miss_data;
        s_mem_done ##0 !mem_write_o |=> cpu_rdata_o == $past(mem_rdata_i) && !cpu_hit_o;
    endproperty
    a_miss_data: assert property (p_miss_data) else $error("miss data wrong");
    property p_write_ack; s_mem_done ##0 mem_write_o |=> cpu_rdata_o == 16'h0000; endproperty
    a_write_ack: assert property (p_write_ack) else $error("write read data");
    property p_reg_valid; internal_register_read_op_i && enable_i |=> reg_valid_o; endproperty
    a_reg_valid: assert property (p_reg_valid) else $error("no read answer");
    property p_clear_off; s_inval ##[1:2] s_stat |=> !internal_cpu_data_bus_o[1]; endproperty
    a_clear_off: assert property (p_clear_off) else $error("present after clear");
    property p_switch_off;
        reg_valid_o && $past(reg_sel_i) == 3'h2 && internal_cpu_data_bus_o[2]
            |-> !internal_cpu_data_bus_o[1];
    endproperty
    a_switch_off: assert property (p_switch_off) else $error("present while off");
endmodule : write_through_cache_monitor

/* File: main_memory_model.sv */
// Behavioural main memory behind the cache
`timescale 1ns/1ps
module main_memory_model
(
    input wire logic clock_i,
    input wire logic mem_req_i,
    input wire logic mem_write_i,
    input wire logic [24:0] mem_addr_i,
    input wire logic [15:0] mem_wdata_i,
    input wire logic [1:0] latency_i,
    output logic mem_ack_o,
    output logic [15:0] mem_rdata_o
);
    logic [15:0] store [logic [24:0]];
    logic [1:0] wait_reg = 2'h0;
    logic served_reg = 1'b0;
    initial mem_ack_o = 1'b0;
    initial mem_rdata_o = 16'h0000;
    // ====================
    // One ack per request after latency_i cycles; data line toggles on every cycle that returns no read data
    always @(posedge clock_i)
    begin
        mem_ack_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        if (!mem_req_i)
        begin
            served_reg <= 1'b0;
            wait_reg <= 2'h0;
        end
        else if (!served_reg && !mem_ack_o)
        begin
            if (wait_reg >= latency_i)
            begin
                mem_ack_o <= 1'b1;
                served_reg <= 1'b1;
                if (mem_write_i)
                    store[mem_addr_i] = mem_wdata_i;
                else
                    mem_rdata_o <= store.exists(mem_addr_i) ? store[mem_addr_i]
                        : mem_addr_i[15:0] ^ 16'h5a5a;
            end
            else
                wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule : main_memory_model

/* File: write_through_cache_tb.sv */
// Self-checking bench for the write-through cache
`timescale 1ns/1ps
module write_through_cache_tb;
    import cache_pkg::*;
    localparam int HOLD = 20;
    logic clock_i = 1'b0, reset_i = 1'b1, req = 1'b0, wr = 1'b0, fch = 1'b0, rdo = 1'b0;
    logic wro = 1'b0, sw = 1'b0, err = 1'b0, fat = 1'b0, dma = 1'b0, efe = 1'b0;
    logic [14:0] page = 15'h0000, lo = 15'h0000, hi = 15'h7fff;
    logic [9:0] disp = 10'h000;
    logic [15:0] wd = 16'h0000, bin = 16'h0000, rdata, bout, mwd, mrd, got, bout_absent;
    logic [2:0] sel = 3'h0;
    logic [4:0] code = 5'h00;
    logic [23:0] ea = 24'h000000;
    logic [1:0] lat = 2'h0;
    logic ack, hit, rv, mreq, mwr, mack;
    logic [24:0] maddr;
    logic ref_v [1024];
    logic [14:0] ref_t [1024];
    logic [15:0] ref_m [logic [24:0]];
    int fails = 0, n_tests = 0, seed = 78845, i;
    write_through_cache #(.PRESENT_HOLD(HOLD), .OPTION_PRESENT(1'b1)) u_dut (
        .clock_i(clock_i), .reset_i(reset_i), .enable_i(1'b1), .cpu_req_i(req),
        .cpu_write_i(wr), .cpu_fetch_i(fch), .physical_page_number_i(page),
        .cpu_disp_i(disp), .cpu_wdata_i(wd), .cpu_ack_o(ack), .cpu_rdata_o(rdata),
        .cpu_hit_o(hit), .internal_register_read_op_i(rdo),
        .internal_register_write_op_i(wro), .reg_sel_i(sel), .internal_cpu_data_bus_i(bin),
        .internal_cpu_data_bus_o(bout), .reg_valid_o(rv), .switch_disable_i(sw),
        .mem_req_o(mreq), .mem_write_o(mwr), .mem_addr_o(maddr), .mem_wdata_o(mwd),
        .mem_ack_i(mack), .mem_rdata_i(mrd), .mem_error_i(err), .mem_fatal_i(fat),
        .mem_code_i(code), .mem_err_addr_i(ea), .mem_err_dma_i(dma), .mem_err_fetch_i(efe));
    main_memory_model u_mem (.clock_i(clock_i), .mem_req_i(mreq), .mem_write_i(mwr),
        .mem_addr_i(maddr), .mem_wdata_i(mwd), .latency_i(lat), .mem_ack_o(mack),
        .mem_rdata_o(mrd));
    // Second copy built without the cache option, only its status word is checked
    write_through_cache #(.PRESENT_HOLD(HOLD), .OPTION_PRESENT(1'b0)) u_dut_absent (
        .clock_i(clock_i), .reset_i(reset_i), .enable_i(1'b1), .cpu_req_i(1'b0),
        .cpu_write_i(1'b0), .cpu_fetch_i(1'b0), .physical_page_number_i(page),
        .cpu_disp_i(disp), .cpu_wdata_i(wd), .cpu_ack_o(), .cpu_rdata_o(), .cpu_hit_o(),
        .internal_register_read_op_i(rdo), .internal_register_write_op_i(wro),
        .reg_sel_i(sel), .internal_cpu_data_bus_i(bin), .internal_cpu_data_bus_o(bout_absent),
        .reg_valid_o(), .switch_disable_i(1'b0), .mem_req_o(), .mem_write_o(), .mem_addr_o(),
        .mem_wdata_o(), .mem_ack_i(1'b0), .mem_rdata_i(16'h0000), .mem_error_i(1'b0),
        .mem_fatal_i(1'b0), .mem_code_i(5'h00), .mem_err_addr_i(24'h000000),
        .mem_err_dma_i(1'b0), .mem_err_fetch_i(1'b0));
    // Clock of 10 ns
    initial forever #5 clock_i = ~clock_i;
    // ====================
    // Compare and report tasks
    task cmp(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task results;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    // Expected memory word: last write, else the model's fill pattern
    function automatic logic [15:0] exp_word(input logic [24:0] a);
        return ref_m.exists(a) ? ref_m[a] : a[15:0] ^ 16'h5a5a;
    endfunction : exp_word
    // ====================
    // Register and CPU access tasks
    task wr_reg(input logic [2:0] s, input logic [15:0] v);
        @(negedge clock_i);
        sel = s;
        bin = v;
        wro = 1'b1;
        @(negedge clock_i);
        wro = 1'b0;
        if (s == SEL_INHIBIT_LOWER) lo = v[14:0];
        if (s == SEL_INHIBIT_UPPER) hi = v[14:0];
        if (s == SEL_INVALIDATE_ALL) ref_v = '{default: 1'b0};
    endtask : wr_reg
    task rd_reg(input logic [2:0] s);
        int k;
        @(negedge clock_i);
        sel = s;
        rdo = 1'b1;
        @(negedge clock_i);
        rdo = 1'b0;
        for (k = 0; k < 4 && rv !== 1'b1; k++) @(negedge clock_i);
        if (rv !== 1'b1) begin fails++; results(); end
        got = bout;
    endtask : rd_reg
    task acc(input logic w, input logic [14:0] p, input logic [9:0] d, input logic [15:0] v);
        logic c;
        logic eh;
        logic [15:0] ed;
        int k;
        c = !(lo <= p && p <= hi) && !sw;
        eh = !w && c && ref_v[d] === 1'b1 && ref_t[d] == p;
        ed = w ? 16'h0000 : exp_word({p, d});
        if (w) ref_m[{p, d}] = v;
        if (c) begin ref_v[d] = 1'b1; ref_t[d] = p; end
        @(negedge clock_i);
        {req, wr, page, disp, wd, fch} = {1'b1, w, p, d, v, 1'($random(seed))};
        for (k = 0; k < 40 && ack !== 1'b1; k++) @(negedge clock_i);
        if (ack !== 1'b1) begin fails++; results(); end
        cmp({15'h0000, hit}, {15'h0000, eh});
        cmp(rdata, ed);
        req = 1'b0;
    endtask : acc
    task err_case(input logic [23:0] a, input logic [4:0] c, input logic f, input logic [1:0] fl);
        @(negedge clock_i);
        {ea, code, fat, dma, efe, err} = {a, c, f, fl, 1'b1};
        @(negedge clock_i);
        {ea, code, err} = {~a, 5'h00, 1'b0};
        acc(1'b0, 15'h0001, 10'h011, 16'h0000);
        rd_reg(SEL_ERROR_STATUS_WORD);
        cmp(got, {fl[0], fl[1], f, c, a[23:16]});
        rd_reg(SEL_ERROR_ADDRESS_LOW);
        cmp(got, a[15:0]);
    endtask : err_case
    // ====================
    // Main sequence
    initial
    begin
        ref_v = '{default: 1'b0};
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        reset_i = 1'b0;
        rd_reg(SEL_CACHE_STATUS_WORD);
        cmp(got & 16'h0006, 16'h0000);
        cmp(bout_absent & 16'h0004, 16'h0004);
        repeat (HOLD + 5) @(negedge clock_i);
        rd_reg(SEL_CACHE_STATUS_WORD);
        cmp(got & 16'h0007, 16'h0002);
        acc(1'b0, 15'h0002, 10'h005, 16'h0000);
        acc(1'b0, 15'h0002, 10'h005, 16'h0000);
        wr_reg(SEL_INHIBIT_LOWER, 16'h0001);
        wr_reg(SEL_INHIBIT_UPPER, 16'h0000);
        acc(1'b0, 15'h0002, 10'h005, 16'h0000);
        rd_reg(SEL_CACHE_STATUS_WORD);
        cmp(got & 16'h0001, 16'h0001);
        acc(1'b0, 15'h0002, 10'h005, 16'h0000);
        acc(1'b1, 15'h0002, 10'h005, 16'hbeef);
        acc(1'b0, 15'h0002, 10'h005, 16'h0000);
        acc(1'b1, 15'h0006, 10'h005, 16'h1234);
        acc(1'b0, 15'h0002, 10'h005, 16'h0000);
        wr_reg(SEL_INVALIDATE_ALL, 16'h0000);
        rd_reg(SEL_CACHE_STATUS_WORD);
        cmp(got & 16'h0002, 16'h0000);
        repeat (HOLD + 5) @(negedge clock_i);
        acc(1'b0, 15'h0006, 10'h005, 16'h0000);
        wr_reg(SEL_INHIBIT_LOWER, 16'h0002);
        wr_reg(SEL_INHIBIT_UPPER, 16'h0002);
        acc(1'b0, 15'h0002, 10'h005, 16'h0000);
        acc(1'b0, 15'h0002, 10'h005, 16'h0000);
        rd_reg(SEL_CACHE_STATUS_WORD);
        cmp(got & 16'h0001, 16'h0000);
        sw = 1'b1;
        repeat (5) @(negedge clock_i);
        rd_reg(SEL_CACHE_STATUS_WORD);
        cmp(got & 16'h0006, 16'h0004);
        acc(1'b0, 15'h0007, 10'h005, 16'h0000);
        acc(1'b0, 15'h0007, 10'h005, 16'h0000);
        sw = 1'b0;
        repeat (5) @(negedge clock_i);
        err_case(24'h3c1234, 5'h04, 1'b0, 2'h1);
        err_case(24'h5a8765, 5'h1f, 1'b1, 2'h2);
        {ea, fat} = {24'h0a0b0c, 1'b0};
        acc(1'b0, 15'h0001, 10'h011, 16'h0000);
        rd_reg(SEL_ERROR_STATUS_WORD);
        cmp(got & 16'h1fff, 16'h000a);
        wr_reg(SEL_INHIBIT_LOWER, 16'h0003);
        wr_reg(SEL_INHIBIT_UPPER, 16'h0003);
        for (i = 0; i < 80; i++)
        begin
            lat = 2'($random(seed));
            acc(1'($random(seed)), 15'($random(seed)) & 15'h0003, 10'($random(seed)) & 10'h007,
                16'($random(seed)));
        end
        results();
    end
endmodule : write_through_cache_tb
bind write_through_cache write_through_cache_monitor #(.PRESENT_HOLD(PRESENT_HOLD),
    .OPTION_PRESENT(OPTION_PRESENT)) u_mon (.clock_i(clock_i), .reset_i(reset_i),
    .enable_i(enable_i), .cpu_write_i(cpu_write_i),
    .physical_page_number_i(physical_page_number_i), .cpu_disp_i(cpu_disp_i),
    .cpu_wdata_i(cpu_wdata_i), .cpu_ack_o(cpu_ack_o), .cpu_rdata_o(cpu_rdata_o),
    .cpu_hit_o(cpu_hit_o), .internal_register_read_op_i(internal_register_read_op_i),
    .internal_register_write_op_i(internal_register_write_op_i), .reg_sel_i(reg_sel_i),
    .internal_cpu_data_bus_o(internal_cpu_data_bus_o), .reg_valid_o(reg_valid_o),
    .mem_req_o(mem_req_o), .mem_write_o(mem_write_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
